/* File: design/cgcr_pkg.sv */
// Constants and types for the counter group register bank.
// Assumes one 100 MHz clock and an active-low async reset.
package cgcr_pkg;
    // Page offsets, byte addresses
    localparam logic [11:0] OFF_CAPS  = 12'he00;
    localparam logic [11:0] OFF_CTRL  = 12'he04;
    localparam logic [11:0] OFF_IIDR  = 12'he08;
    localparam logic [11:0] OFF_EVL0  = 12'he20;
    localparam logic [11:0] OFF_EVL1  = 12'he24;
    localparam logic [11:0] OFF_EVH0  = 12'he28;
    localparam logic [11:0] OFF_EVH1  = 12'he2c;
    localparam logic [11:0] OFF_IRQC  = 12'he50;
    localparam logic [11:0] OFF_IRQA  = 12'he54;
    localparam logic [11:0] OFF_CAPT  = 12'hd88;
    localparam int          ADDR_W    = 17;
    localparam int          PAGE_BIT  = 16;
    // Capability field positions, and the enable bit of written words
    localparam int CAP_TAG   = 24;
    localparam int CAP_SHARE = 23;
    localparam int CAP_CAPT  = 22;
    localparam int CAP_MSI   = 21;
    localparam int CAP_RELOC = 20;
    localparam int SIZE_LSB  = 8;
    localparam int CNTS_LSB  = 0;
    localparam int EN_BIT    = 0;
    // Build options of this group
    localparam logic       HAS_MSI  = 1'b1;
    localparam logic       HAS_TAG  = 1'b1;
    localparam logic       SHARED   = 1'b0;
    localparam logic       HAS_CAPT = 1'b1;
    localparam logic       RELOC    = 1'b1;
    localparam logic [5:0] SIZE_M1  = 6'h2f;
    localparam int         NUM_CNT  = 4;
    localparam logic [5:0] CNTS_M1  = 6'h03;
    // Identification, values arbitrary
    localparam logic [11:0] PRODUCT   = 12'h5a5;
    localparam logic [3:0]  VARIANT   = 4'h1;
    localparam logic [3:0]  MINOR_REV = 4'h2;
    localparam logic [3:0]  JEP_CONT  = 4'h6;
    localparam logic [6:0]  JEP_IDENT = 7'h2d;
    // Countable events bitmaps
    localparam logic [63:0] EV_LOW  = 64'h0000_0000_0000_00ff;
    localparam logic [63:0] EV_HIGH = 64'h0000_0000_0000_0003;
    // Register bus request
    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } cgcr_req_t;
    // MSI tag carried with a message
    typedef struct packed {
        logic        valid;
        logic [15:0] partition_id;
        logic [7:0]  monitor_group_id;
    } cgcr_msi_t;
    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_ON    = 3'b010,
        ST_DRAIN = 3'b100
    } cgcr_ack_st_t;
endpackage

/* File: design/cgcr_irq_ack.sv */
// Acknowledge tracker for the group interrupt enable.
// Assumes msi_busy is a level from the MSI engine on clk.
`timescale 1ns/100ps
module cgcr_irq_ack import cgcr_pkg::*; (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic irq_en,
    input  wire logic msi_busy,
    output logic      ack_r,
    output logic      live_r
);
    cgcr_ack_st_t st_r;
    // Ack falls only once earlier MSIs have drained
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_OFF;
        end else begin
            unique case (st_r)
                ST_OFF:   if (irq_en) st_r <= ST_ON;
                ST_ON:    if (!irq_en) st_r <= ST_DRAIN;
                ST_DRAIN: begin
                    if (irq_en) st_r <= ST_ON;
                    else if (!msi_busy) st_r <= ST_OFF;
                end
            endcase
        end
    end
    // Outputs follow the state one edge later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r  <= 1'b0;
            live_r <= 1'b0;
        end else begin
            ack_r  <= (st_r != ST_OFF);
            live_r <= (st_r == ST_ON) && irq_en;
        end
    end
endmodule

/* File: design/cgcr_cnt_gate.sv */
// Per-counter enable gating and interrupt cause detection.
// Assumes overflow pulses are one cycle wide on clk.
`timescale 1ns/100ps
module cgcr_cnt_gate import cgcr_pkg::*; (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               global_en,
    input  wire logic               irq_live,
    input  wire logic [NUM_CNT-1:0] cnt_en,
    input  wire logic [NUM_CNT-1:0] cnt_irq_en,
    input  wire logic [NUM_CNT-1:0] ovf,
    output logic      [NUM_CNT-1:0] count_en_r,
    output logic                    irq_r
);
    logic [NUM_CNT-1:0] cause;
    // Global enable overrides each counter enable
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) count_en_r[i] <= 1'b0;
            else count_en_r[i] <= global_en & cnt_en[i];
        end
        assign cause[i] = ovf[i] & cnt_irq_en[i];
    end
    // Interrupt pulse only while the group enable is live
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) irq_r <= 1'b0;
        else irq_r <= irq_live & (|cause);
    end
endmodule

/* File: design/cgcr_regs.sv */
// Register bank of one performance counter group.
// Assumes bus and counter signals are on clk; reads answer next edge.
//
// Summary of operation
// - Bit 24 reports MSI partition tagging support
// - Untagged group sends MSIs with zero tags
// - Bit 23 reports shared filter mode
// - Bit 22 reports capture; else capture is zero
// - Bit 21 reports MSI capability
// - Bit 20 relocates the capture trigger to page one
// - Bits 13:8 give legal counter width minus one
// - Bits 5:0 give counter count minus one
// - Group MSI support ignores core MSI flag
// - Global enable clear freezes all counters
// - Global enable overrides per-counter enables
// - Ident holds product, variant, revision, implementer
// - Implementer is continuation, zero, identification code
// - Implemented ident never has zero implementer
// - Low bitmap marks countable events 0 to 63
// - High bitmap marks countable events 64 to 127
// - Interrupt control bit 0 enables, rest zero
// - Interrupt needs group and counter enables
// - Enable clear acknowledged after MSIs drain
`timescale 1ns/100ps
module cgcr_regs import cgcr_pkg::*; (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire cgcr_req_t          bus_req,
    output logic [31:0]             bus_rdata_r,
    output logic                    bus_ack_r,
    input  wire logic [NUM_CNT-1:0] cnt_enable,
    input  wire logic [NUM_CNT-1:0] cnt_irq_enable,
    input  wire logic [NUM_CNT-1:0] cnt_overflow,
    input  wire logic               msi_busy,
    input  wire cgcr_msi_t          msi_in,
    output cgcr_msi_t               msi_out_r,
    output logic [NUM_CNT-1:0]      count_enable_r,
    output logic                    group_irq_r,
    output logic                    capture_r,
    output logic                    irq_ack_r
);

    logic        ctrl_en_r;
    logic        irq_en_r;
    logic        irq_live;
    logic        on_page1;
    logic [11:0] offs;
    logic        rd;
    logic        wr;
    logic        capt_here;
    logic [31:0] caps;
    logic [31:0] iidr;
    logic [31:0] rdata_nxt;

    // Address split into page and offset
    assign on_page1 = bus_req.addr[PAGE_BIT];
    assign offs     = bus_req.addr[11:0];
    assign rd       = bus_req.req && !bus_req.we;
    assign wr       = bus_req.req && bus_req.we;

    // Capture trigger decodes on page one when relocated
    assign capt_here = (offs == OFF_CAPT)
                       && (on_page1 == RELOC);

    // Capability word; core MSI flag plays no part
    always_comb begin
        caps = 32'h0;
        caps[CAP_TAG]   = HAS_MSI & HAS_TAG;
        caps[CAP_SHARE] = SHARED;
        caps[CAP_CAPT]  = HAS_CAPT;
        caps[CAP_MSI]   = HAS_MSI;
        caps[CAP_RELOC] = RELOC;
        caps[SIZE_LSB +: 6] = SIZE_M1;
        caps[CNTS_LSB +: 6] = CNTS_M1;
    end

    // Identification word
    assign iidr = {PRODUCT, VARIANT, MINOR_REV,
                   JEP_CONT, 1'b0, JEP_IDENT};

    // Read mux; unmapped and other-page reads give zero
    always_comb begin
        rdata_nxt = 32'h0;
        if (!on_page1) begin
            unique case (offs)
                OFF_CAPS: rdata_nxt = caps;
                OFF_CTRL: rdata_nxt = {31'h0, ctrl_en_r};
                OFF_IIDR: rdata_nxt = iidr;
                OFF_EVL0: rdata_nxt = EV_LOW[31:0];
                OFF_EVL1: rdata_nxt = EV_LOW[63:32];
                OFF_EVH0: rdata_nxt = EV_HIGH[31:0];
                OFF_EVH1: rdata_nxt = EV_HIGH[63:32];
                OFF_IRQC: rdata_nxt = {31'h0, irq_en_r};
                OFF_IRQA: rdata_nxt = {31'h0, irq_ack_r};
                default:  rdata_nxt = 32'h0;
            endcase
        end
    end

    // Read answer, one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata_r <= 32'h0;
            bus_ack_r   <= 1'b0;
        end else begin
            bus_ack_r   <= bus_req.req;
            bus_rdata_r <= rd ? rdata_nxt : 32'h0;
        end
    end

    // Global counting enable; other offsets never touch it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_en_r <= 1'b0;
        end else if (wr && !on_page1 && offs == OFF_CTRL) begin
            ctrl_en_r <= bus_req.wdata[EN_BIT];
        end
    end

    // Group interrupt enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_en_r <= 1'b0;
        end else if (wr && !on_page1 && offs == OFF_IRQC) begin
            irq_en_r <= bus_req.wdata[EN_BIT];
        end
    end

    // Capture pulse, only when capture is built in
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capture_r <= 1'b0;
        end else begin
            capture_r <= HAS_CAPT && wr && capt_here
                         && bus_req.wdata[EN_BIT];
        end
    end

    // MSI tags pass only when tagging is supported
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            msi_out_r <= '0;
        end else begin
            msi_out_r.valid <= HAS_MSI & msi_in.valid;
            msi_out_r.partition_id <= HAS_TAG ?
                msi_in.partition_id : 16'h0;
            msi_out_r.monitor_group_id <= HAS_TAG ?
                msi_in.monitor_group_id : 8'h0;
        end
    end

    // Enable acknowledge and interrupt liveness
    cgcr_irq_ack u_ack (
        .clk      (clk),
        .rstn     (rstn),
        .irq_en   (irq_en_r),
        .msi_busy (msi_busy),
        .ack_r    (irq_ack_r),
        .live_r   (irq_live)
    );

    // Counter gating and interrupt cause; enable masks the live lag
    cgcr_cnt_gate u_gate (
        .clk        (clk),
        .rstn       (rstn),
        .global_en  (ctrl_en_r),
        .irq_live   (irq_live && irq_en_r),
        .cnt_en     (cnt_enable),
        .cnt_irq_en (cnt_irq_enable),
        .ovf        (cnt_overflow),
        .count_en_r (count_enable_r),
        .irq_r      (group_irq_r)
    );

    // Checks of the read values and behaviour

    sequence s_rd(logic [11:0] o);
        rd && !on_page1 && offs == o;
    endsequence

    sequence s_en_drop;
        irq_en_r ##1 !irq_en_r;
    endsequence

    sequence s_busy_wait;
        msi_busy [*3];
    endsequence

    sequence s_en_rise;
        !irq_en_r ##1 irq_en_r;
    endsequence

    a_tag_bit_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[CAP_TAG] == (HAS_MSI & HAS_TAG))
        else $error("Tag bit wrong");

    a_msi_tag_zero: assert property (@(posedge clk) disable iff (!rstn)
        msi_out_r.valid && !HAS_TAG |->
        msi_out_r.partition_id == 16'h0 && msi_out_r.monitor_group_id == 8'h0)
        else $error("Untagged MSI carries tag");

    a_share_bit_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[CAP_SHARE] == SHARED)
        else $error("Share bit wrong");

    a_capture_cause: assert property (@(posedge clk) disable iff (!rstn)
        capture_r |-> HAS_CAPT && $past(wr && capt_here))
        else $error("Capture without trigger");

    a_msi_bit_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[CAP_MSI] == HAS_MSI)
        else $error("MSI bit wrong");

    a_reloc_page0_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd && RELOC && !on_page1 && offs == OFF_CAPT |=> bus_rdata_r == 32'h0)
        else $error("Relocated slot not zero");

    a_size_legal: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[13:8] inside
        {6'h1f, 6'h23, 6'h27, 6'h2b, 6'h2f, 6'h3f})
        else $error("Counter width code reserved");

    a_cntnum_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[5:0] == 6'(NUM_CNT - 1))
        else $error("Counter count wrong");

    a_count_frozen: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl_en_r ##1 !ctrl_en_r |-> count_enable_r == '0)
        else $error("Counting while globally off");

    a_count_follow: assert property (@(posedge clk) disable iff (!rstn)
        ctrl_en_r |=> count_enable_r == $past(cnt_enable))
        else $error("Counter enable not passed");

    a_ident_nonzero: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_IIDR) |=> bus_rdata_r[6:0] != 7'h0 && bus_rdata_r[7] == 1'b0)
        else $error("Implementer code invalid");

    a_evmap_low: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_EVL0) |=> bus_rdata_r == EV_LOW[31:0])
        else $error("Low event map wrong");

    a_evmap_high: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_EVH1) |=> bus_rdata_r == EV_HIGH[63:32])
        else $error("High event map wrong");

    a_irqc_reserved: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_IRQC) |=> bus_rdata_r[31:1] == 31'h0)
        else $error("Reserved interrupt bits set");

    a_irq_cause: assert property (@(posedge clk) disable iff (!rstn)
        group_irq_r |-> $past(irq_en_r) &&
        $past(|(cnt_overflow & cnt_irq_enable)))
        else $error("Interrupt without cause");

    a_drain_hold: assert property (@(posedge clk) disable iff (!rstn)
        s_en_drop ##0 s_busy_wait |=> irq_ack_r)
        else $error("Ack dropped with MSIs in flight");

    a_quiet_after: assert property (@(posedge clk) disable iff (!rstn)
        !irq_ack_r && !irq_en_r |=> !group_irq_r)
        else $error("Interrupt after disable ack");

    a_ro_ignore: assert property (@(posedge clk) disable iff (!rstn)
        wr && offs != OFF_CTRL |=> ctrl_en_r == $past(ctrl_en_r))
        else $error("Read-only write had effect");

    a_caps_reserved: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[31:25] == 7'h0 && bus_rdata_r[19:14] == 6'h0
        && bus_rdata_r[7:6] == 2'h0)
        else $error("Reserved capability bits set");

    a_capt_bit_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[CAP_CAPT] == HAS_CAPT)
        else $error("Capture bit wrong");

    a_reloc_bit_read: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CAPS) |=> bus_rdata_r[CAP_RELOC] == RELOC)
        else $error("Relocation bit wrong");

    a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CTRL) |=> bus_rdata_r[31:1] == 31'h0)
        else $error("Reserved control bits set");

    a_ctrl_readback: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_CTRL) |=> bus_rdata_r[0] == $past(ctrl_en_r))
        else $error("Control read differs");

    a_ctrl_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && !on_page1 && offs == OFF_CTRL |=> ctrl_en_r == $past(bus_req.wdata[EN_BIT]))
        else $error("Control write lost");

    a_irqc_readback: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_IRQC) |=> bus_rdata_r[0] == $past(irq_en_r))
        else $error("Interrupt enable read differs");

    a_group_irq_enable_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && !on_page1 && offs == OFF_IRQC |=> irq_en_r == $past(bus_req.wdata[EN_BIT]))
        else $error("Interrupt enable write lost");

    a_group_irq_enable_ignore: assert property (@(posedge clk) disable iff (!rstn)
        wr && offs != OFF_IRQC |=> irq_en_r == $past(irq_en_r))
        else $error("Interrupt enable changed by other write");

    a_ident_fields: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_IIDR) |=> bus_rdata_r[31:20] == PRODUCT && bus_rdata_r[19:16] == VARIANT
        && bus_rdata_r[15:12] == MINOR_REV)
        else $error("Ident fields wrong");

    a_ident_maker: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_IIDR) |=> bus_rdata_r[11:8] == JEP_CONT && bus_rdata_r[6:0] == JEP_IDENT)
        else $error("Implementer fields wrong");

    a_evmap_low_hi: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_EVL1) |=> bus_rdata_r == EV_LOW[63:32])
        else $error("Low event map upper word wrong");

    a_evmap_high_lo: assert property (@(posedge clk) disable iff (!rstn)
        s_rd(OFF_EVH0) |=> bus_rdata_r == EV_HIGH[31:0])
        else $error("High event map lower word wrong");

    a_capture_page1: assert property (@(posedge clk) disable iff (!rstn)
        wr && on_page1 && offs == OFF_CAPT && bus_req.wdata[EN_BIT]
        |=> capture_r == (HAS_CAPT && RELOC))
        else $error("Relocated capture not taken");

    a_page1_read_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd && on_page1 |=> bus_rdata_r == 32'h0)
        else $error("Page one read not zero");

    a_write_rdata_zero: assert property (@(posedge clk) disable iff (!rstn)
        wr |=> bus_rdata_r == 32'h0)
        else $error("Write returned data");

    a_msi_tag_pass: assert property (@(posedge clk) disable iff (!rstn)
        msi_in.valid && HAS_TAG |=> msi_out_r.partition_id == $past(msi_in.partition_id)
        && msi_out_r.monitor_group_id == $past(msi_in.monitor_group_id))
        else $error("MSI tag not passed");

    a_irq_needs_ack: assert property (@(posedge clk) disable iff (!rstn)
        group_irq_r |-> $past(irq_ack_r))
        else $error("Interrupt before enable acknowledged");

    a_ack_rise: assert property (@(posedge clk) disable iff (!rstn)
        s_en_rise |-> ##2 irq_ack_r)
        else $error("Enable not acknowledged");

    a_ack_drop: assert property (@(posedge clk) disable iff (!rstn)
        s_en_drop ##1 (!irq_en_r && !msi_busy) |=> ##1 !irq_ack_r)
        else $error("Ack held after drain");

endmodule

/* File: sim/cgcr_regs_bench.sv */
// Self-checking bench for the counter group register bank.
// Assumes the single-cycle req/ack register port and the package build options.
`timescale 1ns/100ps
module cgcr_regs_bench import cgcr_pkg::*;;
    logic               clk;
    logic               rstn;
    cgcr_req_t          bq;
    logic [31:0]        bus_rdata_r;
    logic               bus_ack_r;
    logic [NUM_CNT-1:0] cnt_en;
    logic [NUM_CNT-1:0] cnt_ie;
    logic [NUM_CNT-1:0] cnt_ovf;
    logic               busy;
    cgcr_msi_t          msi_in;
    cgcr_msi_t          msi_out_r;
    logic [NUM_CNT-1:0] count_enable_r;
    logic               group_irq_r;
    logic               capture_r;
    logic               irq_ack_r;
    int                 fails;
    int                 n_tests;
    int                 ncap;
    int                 nirq;
    int                 cyc;
    int                 seed;
    logic [31:0]        expq[$];
    logic [31:0]        rv;
    logic [31:0]        caps_e;
    logic [31:0]        ident_e;
    logic [15:0]        pid;
    logic [7:0]         mid;
    int                 i;

    cgcr_regs DUT (
        .clk            (clk),
        .rstn           (rstn),
        .bus_req        (bq),
        .bus_rdata_r    (bus_rdata_r),
        .bus_ack_r      (bus_ack_r),
        .cnt_enable     (cnt_en),
        .cnt_irq_enable (cnt_ie),
        .cnt_overflow   (cnt_ovf),
        .msi_busy       (busy),
        .msi_in         (msi_in),
        .msi_out_r      (msi_out_r),
        .count_enable_r (count_enable_r),
        .group_irq_r    (group_irq_r),
        .capture_r      (capture_r),
        .irq_ack_r      (irq_ack_r)
    );

    // Clock at 100 MHz
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus access; the expected read data is noted for the monitor
    task automatic acc(input logic w, input logic [16:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        bq <= {1'b1, w, a, d};
        expq.push_back(w ? 32'h0 : e);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            bq      <= '0;
            cnt_ovf <= '0;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Monitor: each answer takes the oldest noted read value
    always @(posedge clk) begin
        if (bus_ack_r === 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("FAIL ack expected none seen %h", bus_rdata_r);
            end else
                chk("rdata", expq.pop_front(), bus_rdata_r);
        end
        if (capture_r === 1'b1) ncap++;
        if (group_irq_r === 1'b1) nirq++;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 3000) begin
            fails++;
            $display("FAIL timeout expected done seen hang");
            conclude();
        end
    end

    initial begin
        seed = 32'hc8db;
        rstn = 1'b0; bq = '0; cnt_en = '0; cnt_ie = '0; cnt_ovf = '0; busy = 1'b0; msi_in = '0;
        fails = 0; n_tests = 0; ncap = 0; nirq = 0; cyc = 0;
        caps_e  = {7'h0, HAS_TAG & HAS_MSI, SHARED, HAS_CAPT, HAS_MSI, RELOC, 6'h0, SIZE_M1, 2'h0, CNTS_M1};
        ident_e = {PRODUCT, VARIANT, MINOR_REV, JEP_CONT, 1'b0, JEP_IDENT};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, back to back
        acc(0, {5'h0, OFF_CAPS}, 0, caps_e);
        acc(0, {5'h0, OFF_CTRL}, 0, 32'h0);
        acc(0, {5'h0, OFF_IIDR}, 0, ident_e);
        acc(0, {5'h0, OFF_EVL0}, 0, EV_LOW[31:0]);
        acc(0, {5'h0, OFF_EVL1}, 0, EV_LOW[63:32]);
        acc(0, {5'h0, OFF_EVH0}, 0, EV_HIGH[31:0]);
        acc(0, {5'h0, OFF_EVH1}, 0, EV_HIGH[63:32]);
        acc(0, {5'h0, OFF_IRQC}, 0, 32'h0);
        acc(0, {5'h0, OFF_IIDR}, 0, ident_e);
        idle(2);
        chk("implementer", 32'h1, {31'h0, bus_rdata_r[6:0] != 7'h0});
        idle(1);
        $display("test reset values done");
        // Writes to read-only places leave them unchanged
        rv = $random(seed);
        acc(1, {5'h0, OFF_CAPS}, rv, 0);
        acc(1, {5'h0, OFF_IIDR}, rv, 0);
        acc(1, {5'h0, OFF_EVL0}, rv, 0);
        acc(1, {5'h0, OFF_EVH1}, rv, 0);
        acc(0, {5'h0, OFF_CAPS}, 0, caps_e);
        acc(0, {5'h0, OFF_IIDR}, 0, ident_e);
        acc(0, {5'h0, OFF_EVL0}, 0, EV_LOW[31:0]);
        acc(0, {5'h0, OFF_EVH1}, 0, EV_HIGH[63:32]);
        acc(0, {5'h0, 12'hffc}, 0, 32'h0);
        idle(3);
        $display("test read-only done");
        // Global enable gates the per-counter enables
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            cnt_en <= 4'($random(seed));
            acc(1, {5'h0, OFF_CTRL}, 32'hfffffffe, 0);
            idle(4);
            chk("count_en off", 32'h0, 32'(count_enable_r));
            acc(1, {5'h0, OFF_CTRL}, 32'hffffffff, 0);
            acc(0, {5'h0, OFF_CTRL}, 0, 32'h1);
            idle(4);
            chk("count_en on", 32'(cnt_en), 32'(count_enable_r));
        end
        acc(1, {5'h0, OFF_CTRL}, 32'h0, 0);
        idle(4);
        chk("count_en off", 32'h0, 32'(count_enable_r));
        $display("test global enable done");
        // Capture works only at its relocated place
        i = ncap;
        acc(1, {5'h0, OFF_CAPT}, 32'h1, 0);
        acc(0, {5'h0, OFF_CAPT}, 0, 32'h0);
        idle(4);
        chk("capture page0", i, ncap);
        acc(1, {1'b1, 4'h0, OFF_CAPT}, 32'h1, 0);
        acc(0, {1'b1, 4'h0, OFF_CAPT}, 0, 32'h0);
        idle(4);
        chk("capture page1", i + 1, ncap);
        $display("test capture done");
        // MSI tags pass or are zeroed by build option
        for (i = 0; i < 4; i++) begin
            pid = 16'($random(seed));
            mid = 8'($random(seed));
            @(posedge clk);
            msi_in <= {1'b1, pid, mid};
            @(posedge clk);
            msi_in <= '0;
            @(posedge clk);
            chk("msi", 32'(HAS_TAG ? {1'b1, pid, mid} : {1'b1, 24'h0}), 32'(msi_out_r));
        end
        $display("test msi tags done");
        // Interrupt enable, masking and drain-acknowledged clear
        cnt_ie <= 4'h2;
        @(posedge clk);
        cnt_ovf <= 4'h2;
        idle(3);
        chk("irq disabled", 32'h0, nirq);
        acc(1, {5'h0, OFF_IRQC}, 32'hffffffff, 0);
        idle(1);
        for (i = 0; i < 20 && irq_ack_r !== 1'b1; i++) @(posedge clk);
        chk("ack set", 32'h1, 32'(irq_ack_r));
        acc(0, {5'h0, OFF_IRQC}, 0, 32'h1);
        acc(0, {5'h0, OFF_IRQA}, 0, 32'h1);
        cnt_ovf <= 4'h1;
        idle(3);
        chk("irq masked", 32'h0, nirq);
        @(posedge clk);
        cnt_ovf <= 4'h2;
        idle(3);
        chk("irq raised", 32'h1, nirq);
        busy <= 1'b1;
        acc(1, {5'h0, OFF_IRQC}, 32'h0, 0);
        // Overflow lands in the first cycle after the enable drops
        @(posedge clk);
        bq      <= '0;
        cnt_ovf <= 4'h2;
        idle(7);
        chk("irq after clear", 32'h1, nirq);
        chk("ack held busy", 32'h1, 32'(irq_ack_r));
        busy <= 1'b0;
        for (i = 0; i < 10 && irq_ack_r !== 1'b0; i++) @(posedge clk);
        chk("ack cleared", 32'h0, 32'(irq_ack_r));
        acc(0, {5'h0, OFF_IRQA}, 0, 32'h0);
        idle(4);
        chk("queue empty", 32'h0, expq.size());
        $display("test interrupt done");
        conclude();
    end
endmodule
